// [hdl/exu_execute_unit.sv]
// Local design decisions: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
module exu_execute_unit #(
   parameter int DATA_W = exu_pkg::DATA_W
) (
   input wire logic sys_clk,
   input wire logic srst,
   input wire logic [DATA_W-1:0] src1Bus,
   input wire logic [DATA_W-1:0] src2Bus,
   input wire logic [exu_pkg::IMM_W-1:0] immedBus,
   input wire logic [DATA_W-1:0] pcSourceBus,
   input wire logic squashN,
   input wire logic extIrqIn,
   input wire logic machineResetIn,
   input wire logic exceptionLineNIn,
   output logic exceptionLineNOut,
   output logic exceptionLineNOe,
   input wire logic isMemoryOp,
   input wire logic isBranchOp,
   input wire logic isComputeOp,
   input wire logic isComputeImmOp,
   input wire logic isMoveToSpecial,
   input wire logic isMoveFromSpecial,
   input wire logic isJumpRestore,
   input wire logic isTrapOp,
   input wire logic isMuldivStep,
   input wire logic aluAlwaysDrives,
   input wire logic branchSense,
   input wire logic branchEqSelect,
   input wire logic branchSignedGtSelect,
   input wire logic branchUnsignedHiSelect,
   input wire logic shifterOwnsResult,
   input wire logic shifterOwnsResultLate,
   input wire logic pcMinus4OnResult,
   input wire logic pcIncrOnResult,
   output logic [DATA_W-1:0] mainResultBus,
   output logic [DATA_W-1:0] pcSideResultBus,
   output logic resultBusDriven,
   output logic [DATA_W-1:0] aluResult,
   output logic branchTakenOut,
   output logic pcShiftingBitN,
   output logic userModeBitN,
   output logic phase2Out,
   input wire logic [exu_pkg::REG_ADDR_W-1:0] regAddr,
   input wire logic [DATA_W-1:0] regWdata,
   input wire logic regWr,
   input wire logic regRd,
   output logic [DATA_W-1:0] regRdata
);
   if (DATA_W != exu_pkg::DATA_W) begin : g_chk
      $error("exu_execute_unit serves 32-bit data only");
   end

   function automatic logic [7:0] oneHot8(input logic [2:0] v);
      oneHot8 = 8'h01 << v;
   endfunction

   function automatic logic [3:0] oneHot4(input logic [1:0] v);
      oneHot4 = 4'h1 << v;
   endfunction

   // phase 1 is the precharge/compute half, phase 2 the evaluate/drive half
   logic phaseQ;
   logic phaseD;
   wire logic phase1Now;
   wire logic phase2Now;
   assign phaseD = ~phaseQ;
   assign phase1Now = ~phaseQ;
   assign phase2Now = phaseQ;

   logic [exu_pkg::SW_W-1:0] statusQ;
   logic [exu_pkg::SW_W-1:0] statusD;
   logic [exu_pkg::SW_W-1:0] savedStatusQ;
   logic [DATA_W-1:0] muldivQ;
   logic [DATA_W-1:0] muldivD;
   logic [DATA_W-1:0] shiftResultQ;
   logic [DATA_W-1:0] aluResultQ;
   logic [DATA_W-1:0] src1Q;
   logic aluDrivesQ;
   logic moveFromQ;
   // phase 1 flags kept for the phase 2 status update, as the decoder may drop them
   logic moveToQ;
   logic restoreQ;
   logic trapQ;
   logic takenQ;
   logic ovfQ;
   logic excSeenQ;
   logic [DATA_W-1:0] regRdataQ;

   // shifter input selection
   wire exu_pkg::exu_shmode_t shMode;
   wire logic byteRot;
   wire logic [4:0] shAmt;
   wire logic [DATA_W-1:0] signWord;
   logic [DATA_W-1:0] shOperand2;
   wire logic [7:0] stage1Sel;
   wire logic [3:0] stage2Sel;
   wire logic [DATA_W-1:0] shField;

   assign shMode = exu_pkg::exu_shmode_t'(immedBus[exu_pkg::IMM_MODE_LSB +: 2]);
   assign byteRot = immedBus[exu_pkg::IMM_BYTE_ROT];
   // byte rotates take their amount from src1, whole bytes only
   assign shAmt = byteRot ? {src1Bus[1:0], 3'b000} : immedBus[exu_pkg::IMM_AMT_LSB +: 5];
   assign signWord = {DATA_W{src1Bus[DATA_W-1]}}; // [RQ20]

   always_comb begin
      case (shMode)
         exu_pkg::SHM_FUNNEL: shOperand2 = src2Bus; // [RQ19]
         exu_pkg::SHM_ROTATE: shOperand2 = src1Bus; // [RQ19]
         exu_pkg::SHM_ARITH: shOperand2 = signWord; // [RQ19]
         default: shOperand2 = src2Bus;
      endcase
   end

   // non-shift instructions leave only pass-zero and shift-zero lines high
   assign stage1Sel = shifterOwnsResult ? oneHot8(shAmt[4:2]) : 8'h01; // [RQ18] [RQ21]
   assign stage2Sel = shifterOwnsResult ? oneHot4(shAmt[1:0]) : 4'h1; // [RQ18] [RQ21]

   exu_funnel_shifter #(
      .DATA_W(DATA_W)
   ) u_shifter (
      .hiWord(src1Bus),
      .loWord(shOperand2),
      .stage1Sel(stage1Sel),
      .stage2Sel(stage2Sel),
      .field(shField)
   );

   // simple adder path; memory and immediate forms use the sign-extended immediate
   wire logic useImm;
   wire logic [DATA_W-1:0] immExt;
   wire logic [DATA_W-1:0] aluOperand2;
   wire logic [DATA_W:0] aluSum;
   wire logic aluOvf;
   assign useImm = isMemoryOp | isComputeImmOp;
   assign immExt = {{(DATA_W-exu_pkg::IMM_W){immedBus[exu_pkg::IMM_W-1]}}, immedBus};
   assign aluOperand2 = useImm ? immExt : src2Bus;
   assign aluSum = {1'b0, src1Bus} + {1'b0, aluOperand2};
   assign aluOvf = (src1Bus[DATA_W-1] == aluOperand2[DATA_W-1])
                   & (aluSum[DATA_W-1] != src1Bus[DATA_W-1]);

   // branch conditions
   wire logic condEq;
   wire logic condGt;
   wire logic condHi;
   wire logic condMet;
   wire logic takenNow;
   assign condEq = src1Bus == src2Bus;
   assign condGt = $signed(src1Bus) > $signed(src2Bus);
   assign condHi = src1Bus > src2Bus;
   assign condMet = (branchEqSelect & condEq) | (branchSignedGtSelect & condGt)
                    | (branchUnsignedHiSelect & condHi); // [RQ8]
   assign takenNow = isBranchOp & (branchSense ? ~condMet : condMet); // [RQ7] [RQ9]

   // muldiv step shifts left one place, pulling in the adder carry
   wire logic freeze;
   assign freeze = ~squashN; // [RQ23]
   always_comb begin
      muldivD = muldivQ;
      if (phase1Now && isMuldivStep && !freeze) begin
         muldivD = {muldivQ[DATA_W-2:0], aluSum[DATA_W]}; // [RQ23]
      end
   end

   // status word: software port wins over instruction effects
   wire logic swWrite;
   assign swWrite = regWr & (regAddr == exu_pkg::REG_STATUS);
   always_comb begin
      statusD = statusQ;
      if (swWrite) begin
         statusD = regWdata[exu_pkg::SW_W-1:0];
      end else if (phase2Now && !freeze) begin // [RQ23]
         if (moveToQ) begin
            statusD = src1Q[exu_pkg::SW_W-1:0];
         end else if (restoreQ) begin
            statusD = savedStatusQ;
         end else if (trapQ) begin
            statusD[exu_pkg::SW_USER] = 1'b0;
            statusD[exu_pkg::SW_IRQ_MASK] = 1'b1;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         phaseQ <= 1'b0;
      end else begin
         phaseQ <= phaseD;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst || machineResetIn) begin
         statusQ <= exu_pkg::SW_RESET; // [RQ3]
         savedStatusQ <= exu_pkg::SW_RESET; // [RQ3]
      end else begin
         statusQ <= statusD;
         if (phase2Now && trapQ && !freeze) begin
            savedStatusQ <= statusQ;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         muldivQ <= '0;
      end else if (regWr && regAddr == exu_pkg::REG_MULDIV) begin
         muldivQ <= regWdata;
      end else begin
         muldivQ <= muldivD;
      end
   end

   // shift and ALU results and their flags are latched at the end of phase 1; pcSourceBus goes to the bus unlatched
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         shiftResultQ <= '0;
         aluResultQ <= '0;
         src1Q <= '0;
         aluDrivesQ <= 1'b0;
         moveFromQ <= 1'b0;
         moveToQ <= 1'b0;
         restoreQ <= 1'b0;
         trapQ <= 1'b0;
         takenQ <= 1'b0;
         ovfQ <= 1'b0;
      end else if (phase1Now) begin
         shiftResultQ <= shField; // [RQ16]
         aluResultQ <= aluSum[DATA_W-1:0];
         src1Q <= src1Bus;
         aluDrivesQ <= aluAlwaysDrives; // [RQ6]
         moveFromQ <= isMoveFromSpecial;
         moveToQ <= isMoveToSpecial;
         restoreQ <= isJumpRestore;
         trapQ <= isTrapOp;
         takenQ <= takenNow; // [RQ9]
         ovfQ <= aluOvf & (isComputeOp | isComputeImmOp);
      end
   end

   // result bus: one source only, shifter first, then PC unit, then status word, then ALU
   wire logic selShift;
   wire logic selPc;
   wire logic selAlu;
   wire logic selSpecial;
   logic [DATA_W-1:0] busValue;
   assign selShift = phase2Now & shifterOwnsResultLate; // [RQ22] [RQ14]
   assign selPc = phase2Now & ~selShift & (pcMinus4OnResult | pcIncrOnResult); // [RQ25]
   assign selSpecial = phase2Now & ~selShift & ~selPc & moveFromQ; // [RQ25]
   assign selAlu = phase2Now & ~selShift & ~selPc & ~moveFromQ & aluDrivesQ; // [RQ25]

   always_comb begin
      busValue = '0;
      if (selShift) begin
         busValue = shiftResultQ; // [RQ16] [RQ13]
      end else if (selPc) begin
         busValue = pcSourceBus;
      end else if (selSpecial) begin
         busValue = {{(DATA_W-exu_pkg::SW_W){1'b0}}, statusQ};
      end else if (selAlu) begin
         busValue = aluResultQ; // [RQ13]
      end
   end

   // PC values keep their top bit only on the PC-side copy
   assign mainResultBus = selPc ? {1'b0, busValue[DATA_W-2:0]} : busValue;
   assign pcSideResultBus = {busValue[DATA_W-1], mainResultBus[DATA_W-2:0]}; // [RQ24]
   assign resultBusDriven = selShift | selPc | selSpecial | selAlu;
   assign aluResult = aluResultQ;
   assign branchTakenOut = takenQ; // [RQ9]
   assign pcShiftingBitN = ~statusQ[exu_pkg::SW_PC_SHIFT]; // [RQ10]
   assign userModeBitN = ~statusQ[exu_pkg::SW_USER]; // [RQ10]
   assign phase2Out = phaseQ;

   // open-drain exception line, qualified by the evaluate phase
   wire logic irqReq;
   wire logic ovfReq;
   wire logic pullLine;
   assign irqReq = extIrqIn & ~statusQ[exu_pkg::SW_IRQ_MASK]; // [RQ1]
   assign ovfReq = ovfQ & statusQ[exu_pkg::SW_OVF_EN]; // [RQ2]
   assign pullLine = phase2Now & (irqReq | ovfReq); // [RQ2] [RQ14]
   assign exceptionLineNOut = 1'b0;
   assign exceptionLineNOe = ~pullLine; // [RQ2]

   // sticky record of any party pulling the line in phase 2; a new pull beats a clear
   wire logic lineLow;
   wire logic obsClear;
   assign lineLow = phase2Now & ~exceptionLineNIn;
   assign obsClear = regWr & (regAddr == exu_pkg::REG_OBSERVE)
                     & regWdata[exu_pkg::OB_EXC_SEEN];
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         excSeenQ <= 1'b0;
      end else if (lineLow) begin
         excSeenQ <= 1'b1;
      end else if (obsClear) begin
         excSeenQ <= 1'b0;
      end
   end

   // register read port, data in the cycle after the strobe only
   logic [DATA_W-1:0] rdMux;
   always_comb begin
      case (regAddr)
         exu_pkg::REG_STATUS: rdMux = {{(DATA_W-exu_pkg::SW_W){1'b0}}, statusQ};
         exu_pkg::REG_OBSERVE: rdMux = {{(DATA_W-3){1'b0}}, phaseQ, takenQ, excSeenQ};
         exu_pkg::REG_MULDIV: rdMux = muldivQ;
         default: rdMux = '0;
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         regRdataQ <= '0;
      end else if (regRd) begin
         regRdataQ <= rdMux;
      end else begin
         regRdataQ <= '0;
      end
   end
   assign regRdata = regRdataQ;
endmodule

// [hdl/exu_pkg.sv]
// Contract
// RQ1: unmasked external interrupt pulls exception line
// RQ2: exception line for interrupt, exception, overflow (the unit pulls it for unmasked interrupt and enabled overflow only)
// RQ3: machine reset forces sane status word
// RQ4: one class indicator per instruction ALU cycle
// RQ5: special-instruction indicators active in ALU cycle
// RQ6: ALU drives result when opcode0 and type1
// RQ7: branch sense equals opcode bit 0
// RQ8: exactly one condition select during branch
// RQ9: branch decision valid in branch ALU cycle
// RQ10: status S and U bits output, active low
// RQ11: PC unit flags its result bus sources
// RQ12: inputs stable from RF phase 2 to ALU phase 1
// RQ13: result on bus by ALU phase 2 end
// RQ14: control outputs low outside evaluation phase
// RQ15: shifter extracts any 32-bit field of 64
// RQ16: shift latched phase 1, driven phase 2
// RQ17: three high bits pick window, two low bits finish
// RQ18: eight plus four one-hot stage selects
// RQ19: input mux picks funnel, rotate or arithmetic
// RQ20: sign bit replicated as second shifter word
// RQ21: shift indicator gates decoders for non-shifts
// RQ22: delayed shift indicator gates shifter onto bus
// RQ23: squash freezes muldiv register and status word
// RQ24: PC-side bus differs only in top bit
// RQ25: at most one result bus source per phase 2
package exu_pkg;
   localparam int CLK_PERIOD_NS = 10;
   localparam int PHASES_PER_CYCLE = 2;
   localparam int DATA_W = 32;
   localparam int IMM_W = 17;
   localparam int WIN_W = 35;
   localparam int STAGE1_N = 8;
   localparam int STAGE2_N = 4;
   localparam int REG_ADDR_W = 4;
   localparam logic [3:0] REG_STATUS = 4'h0;
   localparam logic [3:0] REG_OBSERVE = 4'h4;
   localparam logic [3:0] REG_MULDIV = 4'h8;
   // status word fields
   localparam int SW_IRQ_MASK = 0;
   localparam int SW_PC_SHIFT = 1;
   localparam int SW_USER = 2;
   localparam int SW_OVF_EN = 3;
   localparam int SW_W = 4;
   localparam logic [3:0] SW_RESET = 4'h1;
   // observe register fields
   localparam int OB_EXC_SEEN = 0;
   localparam int OB_TAKEN = 1;
   localparam int OB_PHASE2 = 2;
   // shift control fields in the immediate
   localparam int IMM_AMT_LSB = 0;
   localparam int IMM_MODE_LSB = 5;
   localparam int IMM_BYTE_ROT = 7;
   typedef enum logic [1:0] {
      SHM_FUNNEL,
      SHM_ROTATE,
      SHM_ARITH,
      SHM_RSVD
   } exu_shmode_t;
endpackage

// [hdl/exu_funnel_shifter.sv]
`timescale 1ns/1ps
module exu_funnel_shifter #(
   parameter int DATA_W = exu_pkg::DATA_W
) (
   input wire logic [DATA_W-1:0] hiWord,
   input wire logic [DATA_W-1:0] loWord,
   input wire logic [exu_pkg::STAGE1_N-1:0] stage1Sel,
   input wire logic [exu_pkg::STAGE2_N-1:0] stage2Sel,
   output logic [DATA_W-1:0] field
);
   localparam int WIN_W = DATA_W + exu_pkg::STAGE2_N - 1;
   wire logic [2*DATA_W-1:0] joined;
   logic [WIN_W-1:0] window;
   if (DATA_W != exu_pkg::DATA_W) begin : g_chk
      $error("exu_funnel_shifter serves 32-bit data only");
   end
   // left amount n gives joined[63-n -: 32]
   assign joined = {hiWord, loWord}; // [RQ15]
   // wired-or of one-hot selected windows
   always_comb begin
      window = '0;
      for (int k = 0; k < exu_pkg::STAGE1_N; k++) begin
         if (stage1Sel[k]) begin
            window = window | joined[2*DATA_W-1-4*k -: WIN_W]; // [RQ17]
         end
      end
   end
   always_comb begin
      field = '0;
      for (int j = 0; j < exu_pkg::STAGE2_N; j++) begin
         if (stage2Sel[j]) begin
            field = field | window[WIN_W-1-j -: DATA_W]; // [RQ17]
         end
      end
   end
endmodule

// [tb/exu_execute_unit_asserts.sv]
`timescale 1ns/1ps
module exu_execute_unit_asserts #(
   parameter int DATA_W = exu_pkg::DATA_W
) (
   input wire logic sys_clk,
   input wire logic srst,
   input wire logic [DATA_W-1:0] src1Bus,
   input wire logic [DATA_W-1:0] src2Bus,
   input wire logic [DATA_W-1:0] pcSourceBus,
   input wire logic squashN,
   input wire logic machineResetIn,
   input wire logic exceptionLineNOe,
   input wire logic isBranchOp,
   input wire logic branchSense,
   input wire logic branchEqSelect,
   input wire logic shifterOwnsResultLate,
   input wire logic pcMinus4OnResult,
   input wire logic pcIncrOnResult,
   input wire logic [DATA_W-1:0] mainResultBus,
   input wire logic [DATA_W-1:0] pcSideResultBus,
   input wire logic resultBusDriven,
   input wire logic branchTakenOut,
   input wire logic pcShiftingBitN,
   input wire logic userModeBitN,
   input wire logic phase2Out,
   input wire logic regWr
);
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (srst);
   property p_bus_idle;
      !phase2Out |-> mainResultBus == '0 && pcSideResultBus == '0 && !resultBusDriven;
   endproperty
   a_bus_idle: assert property (p_bus_idle) else $error("bus driven in phase 1");
   property p_pc_side;
      pcSideResultBus[DATA_W-2:0] == mainResultBus[DATA_W-2:0];
   endproperty
   a_pc_side: assert property (p_pc_side) else $error("bus copies differ");
   property p_oe_phase;
      !exceptionLineNOe |-> phase2Out;
   endproperty
   a_oe_phase: assert property (p_oe_phase) else $error("line pulled in phase 1");
   property p_phase_alt;
      !srst |=> phase2Out != $past(phase2Out);
   endproperty
   a_phase_alt: assert property (p_phase_alt) else $error("phases do not alternate");
   property p_late_drives;
      phase2Out && shifterOwnsResultLate |-> resultBusDriven;
   endproperty
   a_late_drives: assert property (p_late_drives) else $error("shift result not driven");
   property p_pc_source;
      phase2Out && (pcMinus4OnResult || pcIncrOnResult) && !shifterOwnsResultLate
         |-> mainResultBus == {1'b0, pcSourceBus[DATA_W-2:0]} && pcSideResultBus == pcSourceBus;
   endproperty
   a_pc_source: assert property (p_pc_source) else $error("pc source not on bus");
   property p_taken_eq;
      !phase2Out && isBranchOp && branchEqSelect && !branchSense
         |=> branchTakenOut == ($past(src1Bus) == $past(src2Bus));
   endproperty
   a_taken_eq: assert property (p_taken_eq) else $error("equal branch decision wrong");
   property p_squash;
      !squashN && phase2Out && !regWr && !machineResetIn
         |=> $stable(pcShiftingBitN) && $stable(userModeBitN);
   endproperty
   a_squash: assert property (p_squash) else $error("status changed under squash");
endmodule
bind exu_execute_unit exu_execute_unit_asserts #(.DATA_W(DATA_W)) u_chk (
   .sys_clk, .srst, .src1Bus, .src2Bus, .pcSourceBus, .squashN, .machineResetIn,
   .exceptionLineNOe, .isBranchOp, .branchSense, .branchEqSelect, .shifterOwnsResultLate,
   .pcMinus4OnResult, .pcIncrOnResult, .mainResultBus, .pcSideResultBus, .resultBusDriven,
   .branchTakenOut, .pcShiftingBitN, .userModeBitN, .phase2Out, .regWr
);

// [tb/exu_ireg_model.sv]
`timescale 1ns/1ps
module exu_ireg_model (
   input wire logic sys_clk,
   input wire logic srst,
   input wire logic phase2Out,
   input wire logic [4:0] kind,
   output logic isMemoryOp,
   output logic isBranchOp,
   output logic isComputeOp,
   output logic isComputeImmOp,
   output logic isMoveToSpecial,
   output logic isMoveFromSpecial,
   output logic isJumpRestore,
   output logic isTrapOp,
   output logic isMuldivStep,
   output logic aluAlwaysDrives,
   output logic branchSense,
   output logic branchEqSelect,
   output logic branchSignedGtSelect,
   output logic branchUnsignedHiSelect,
   output logic shifterOwnsResult,
   output logic shifterOwnsResultLate,
   output logic pcMinus4OnResult,
   output logic pcIncrOnResult
);
   logic [2:0] lateQ;
   wire logic [3:0] k = kind[3:0];
   // the bench holds kind only through the phase 1 cycle, so each flag is an ALU-cycle level
   assign isMemoryOp = k == 4'hC;
   assign isBranchOp = k inside {4'h2, 4'h3, 4'h4};
   assign isComputeOp = k == 4'hD;
   assign isComputeImmOp = k == 4'hE;
   assign isMoveToSpecial = k == 4'h7;
   assign isMoveFromSpecial = k == 4'h8;
   assign isTrapOp = k == 4'h9;
   assign isJumpRestore = k == 4'hA;
   assign isMuldivStep = k == 4'hB;
   assign aluAlwaysDrives = k == 4'hF;
   assign branchSense = kind[4];
   assign branchEqSelect = k == 4'h2;
   assign branchSignedGtSelect = k == 4'h3;
   assign branchUnsignedHiSelect = k == 4'h4;
   assign shifterOwnsResult = k == 4'h1;
   // late copies live in the phase 2 cycle only and drop at its end
   always_ff @(posedge sys_clk) begin
      if (srst || phase2Out)
         lateQ <= 3'h0;
      else
         lateQ <= {k == 4'h1, k == 4'h5, k == 4'h6};
   end
   assign shifterOwnsResultLate = lateQ[2];
   assign pcMinus4OnResult = lateQ[1];
   assign pcIncrOnResult = lateQ[0];
endmodule

// [tb/testbench.sv]
`timescale 1ns/1ps
module testbench;
   logic sys_clk, srst, squashN, extIrqIn, machineResetIn, regWr, regRd, cond;
   logic [31:0] src1Bus, src2Bus, pcSourceBus, regWdata, regRdata, aluResult, a, op;
   logic [31:0] mainResultBus, pcSideResultBus;
   logic [63:0] w;
   logic [16:0] immedBus;
   logic [3:0] regAddr;
   logic [4:0] kind;
   logic exceptionLineNOut, exceptionLineNOe, resultBusDriven, branchTakenOut;
   logic pcShiftingBitN, userModeBitN, phase2Out;
   // pull-up on the shared line: released means high
   wire logic exceptionLineNIn = exceptionLineNOe | exceptionLineNOut;
   wire logic isMemoryOp, isBranchOp, isComputeOp, isComputeImmOp, isMoveToSpecial;
   wire logic isMoveFromSpecial, isJumpRestore, isTrapOp, isMuldivStep, aluAlwaysDrives;
   wire logic branchSense, branchEqSelect, branchSignedGtSelect, branchUnsignedHiSelect;
   wire logic shifterOwnsResult, shifterOwnsResultLate, pcMinus4OnResult, pcIncrOnResult;
   int failCount = 0;
   int nChecks = 0;
   int cyc = 0;
   exu_ireg_model u_ireg (.sys_clk, .srst, .phase2Out, .kind, .isMemoryOp, .isBranchOp,
      .isComputeOp, .isComputeImmOp, .isMoveToSpecial, .isMoveFromSpecial, .isJumpRestore,
      .isTrapOp, .isMuldivStep, .aluAlwaysDrives, .branchSense, .branchEqSelect,
      .branchSignedGtSelect, .branchUnsignedHiSelect, .shifterOwnsResult,
      .shifterOwnsResultLate, .pcMinus4OnResult, .pcIncrOnResult);
   exu_execute_unit DUT (.sys_clk, .srst, .src1Bus, .src2Bus, .immedBus, .pcSourceBus,
      .squashN, .extIrqIn, .machineResetIn, .exceptionLineNIn, .exceptionLineNOut,
      .exceptionLineNOe, .isMemoryOp, .isBranchOp, .isComputeOp, .isComputeImmOp,
      .isMoveToSpecial, .isMoveFromSpecial, .isJumpRestore, .isTrapOp, .isMuldivStep,
      .aluAlwaysDrives, .branchSense, .branchEqSelect, .branchSignedGtSelect,
      .branchUnsignedHiSelect, .shifterOwnsResult, .shifterOwnsResultLate, .pcMinus4OnResult,
      .pcIncrOnResult, .mainResultBus, .pcSideResultBus, .resultBusDriven, .aluResult,
      .branchTakenOut, .pcShiftingBitN, .userModeBitN, .phase2Out, .regAddr, .regWdata,
      .regWr, .regRd, .regRdata);
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   task automatic endSim();
      $display("checks %0d mismatches %0d", nChecks, failCount);
      if (failCount == 0 && nChecks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 20000) begin
         failCount++;
         $display("[FAIL] %0t run did not finish", $time);
         endSim();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      nChecks++;
      if (got !== exp) begin
         failCount++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [3:0] ad, input logic [31:0] d);
      @(posedge sys_clk);
      regAddr <= ad;
      regWdata <= d;
      regWr <= 1'b1;
      @(posedge sys_clk);
      regWr <= 1'b0;
      @(negedge sys_clk);
   endtask
   task automatic rdc(input logic [3:0] ad, input logic [31:0] exp);
      @(posedge sys_clk);
      regAddr <= ad;
      regRd <= 1'b1;
      @(posedge sys_clk);
      regRd <= 1'b0;
      @(negedge sys_clk);
      chk(regRdata, exp);
   endtask
   // operands stand through the phase 1 cycle, then flip so a stale latch shows up
   task automatic issue(input logic [4:0] k, input logic [31:0] s1, input logic [31:0] s2,
                        input logic [16:0] im);
      @(negedge sys_clk);
      if (phase2Out !== 1'b1)
         @(negedge sys_clk);
      @(posedge sys_clk);
      kind <= k;
      src1Bus <= s1;
      src2Bus <= s2;
      immedBus <= im;
      @(posedge sys_clk);
      kind <= 5'h00;
      src1Bus <= ~s1;
      src2Bus <= ~s2;
      @(negedge sys_clk);
   endtask
   initial begin
      {srst, squashN, extIrqIn, machineResetIn, regWr, regRd} = 6'b110000;
      {src1Bus, src2Bus, regWdata} = '0;
      pcSourceBus = 32'hFEDC_BA98;
      immedBus = '0;
      regAddr = '0;
      kind = '0;
      repeat (12) @(posedge sys_clk);
      srst <= 1'b0;
      rdc(4'h0, 32'h1);
      chk({30'h0, pcShiftingBitN, userModeBitN}, 32'h3);
      rdc(4'hC, 32'h0);
      wr(4'h8, 32'hA5C3_0F96);
      rdc(4'h8, 32'hA5C3_0F96);
      issue(5'h08, 32'h0, 32'h0, '0);
      chk(mainResultBus, 32'h1);
      for (int m = 0; m < 4; m++) begin
         for (int n = 0; n < 32; n++) begin
            a = 32'h9E37_79B9 ^ 32'(n << 9);
            op = (m == 1) ? a : (m == 2) ? {32{a[31]}} : 32'h1234_5678;
            issue(5'h01, a, 32'h1234_5678, {10'h0, m[1:0], n[4:0]});
            w = {a, op} << n;
            chk(mainResultBus, w[63:32]);
            chk({31'h0, resultBusDriven}, 32'h1);
         end
      end
      for (int b = 0; b < 4; b++) begin
         a = 32'hA1B2_C3D0 | 32'(b);
         issue(5'h01, a, 32'h0, 17'h000A0);
         w = {a, a} << (8 * b);
         chk(mainResultBus, w[63:32]);
      end
      for (int p = 5; p < 7; p++) begin
         issue(5'(p), 32'h0, 32'h0, '0);
         chk(mainResultBus, 32'h7EDC_BA98);
         chk(pcSideResultBus, 32'hFEDC_BA98);
      end
      for (int s = 0; s < 3; s++) begin
         for (int j = 0; j < 4; j++) begin
            a = j[0] ? 32'hFFFF_FFFF : 32'h5;
            op = j[0] ? 32'h1 : 32'h5;
            cond = (s == 0) ? (a == op) : (s == 1) ? ($signed(a) > $signed(op)) : (a > op);
            issue({j[1], 4'(s + 2)}, a, op, '0);
            chk({31'h0, branchTakenOut}, {31'h0, j[1] ^ cond});
         end
      end
      wr(4'h0, 32'h6);
      chk({30'h0, pcShiftingBitN, userModeBitN}, 32'h0);
      @(posedge sys_clk);
      extIrqIn <= 1'b1;
      issue(5'h00, 32'h0, 32'h0, '0);
      chk({31'h0, exceptionLineNOe}, 32'h0);
      wr(4'h0, 32'h7);
      issue(5'h00, 32'h0, 32'h0, '0);
      chk({31'h0, exceptionLineNOe}, 32'h1);
      @(posedge sys_clk);
      extIrqIn <= 1'b0;
      issue(5'h09, 32'h0, 32'h0, '0);
      @(negedge sys_clk);
      chk({31'h0, userModeBitN}, 32'h1);
      issue(5'h0A, 32'h0, 32'h0, '0);
      @(negedge sys_clk);
      chk({31'h0, userModeBitN}, 32'h0);
      @(posedge sys_clk);
      squashN <= 1'b0;
      issue(5'h07, 32'h0, 32'h0, '0);
      issue(5'h0B, 32'h0, 32'h0, '0);
      @(negedge sys_clk);
      chk({30'h0, pcShiftingBitN, userModeBitN}, 32'h0);
      rdc(4'h8, 32'hA5C3_0F96);
      @(posedge sys_clk);
      squashN <= 1'b1;
      issue(5'h07, 32'h0, 32'h0, '0);
      @(negedge sys_clk);
      chk({30'h0, pcShiftingBitN, userModeBitN}, 32'h3);
      issue(5'h0B, 32'hFFFF_FFFF, 32'h1, '0);
      rdc(4'h8, 32'h4B86_1F2D);
      wr(4'h0, 32'h9);
      issue(5'h0D, 32'h7FFF_FFFF, 32'h1, '0);
      chk({31'h0, exceptionLineNOe}, 32'h0);
      issue(5'h0F, 32'h3, 32'h4, '0);
      chk({31'h0, resultBusDriven}, 32'h1);
      chk(mainResultBus, 32'h7);
      chk(aluResult, 32'h7);
      wr(4'h0, 32'h6);
      @(posedge sys_clk);
      machineResetIn <= 1'b1;
      @(posedge sys_clk);
      machineResetIn <= 1'b0;
      rdc(4'h0, 32'h1);
      endSim();
   end
endmodule
